// file: inc/mmc_pkg.sv
// Package: constants and types of the module management control block
package mmc_pkg;
  // Timing
  localparam int CLK_KHZ       = 25000;
  localparam int T_INIT_MS     = 2000;
  localparam int INIT_CYC      = T_INIT_MS * CLK_KHZ;
  localparam int T_RST_MIN_US  = 2;
  // Least time, rounded up to whole cycles
  localparam int RST_MIN_CYC   = (T_RST_MIN_US * CLK_KHZ + 999) / 1000;
  localparam int RST_CNT_W     = 8;
  // Register map (byte addresses)
  localparam int ADDR_W        = 8;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_FLAGS  = 8'h0c;
  localparam logic [7:0] OFS_MASK   = 8'h10;
  localparam logic [7:0] OFS_CTRL   = 8'h14;
  // Status fields
  localparam int STS_DNR       = 0;
  localparam int STS_LP        = 1;
  localparam int STS_RESP      = 2;
  // Control fields
  localparam int CTL_PDOWN     = 0;
  // Flag layout
  localparam int N_CH          = 4;
  localparam int FLAG_W        = 1 + 3 * N_CH;
  localparam int FLG_INIT      = 0;
  localparam int FLG_LOS       = 1;
  localparam int FLG_TXF       = FLG_LOS + N_CH;
  localparam int FLG_OTH       = FLG_TXF + N_CH;
  // Reset values
  localparam logic [FLAG_W-1:0] MASK_RST  = 13'h0000;
  localparam logic              PDOWN_RST = 1'b0;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_INIT,
    ST_RUN
  } mmc_state_e;

  typedef struct packed {
    logic [N_CH-1:0] other;
    logic [N_CH-1:0] tx_fault;
    logic [N_CH-1:0] rx_los;
  } mmc_cond_s;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } mmc_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } mmc_apb_rsp_s;
endpackage

// file: src/mmc_ctrl.sv
// Module management control: reset, init, flags, masks, power and select
// Operation
// [R1] Fully functional within 2000 ms of start
// [R2] Low reset pulse over 2 us resets
// [R3] Serial bus answers within 2000 ms
// [R4] Init clears not-ready, asserts interrupt
// [R5] Reset release leads to full function
// [R6] Low-power input lowers power within 100 us
// [R7] Trigger condition drives interrupt low quickly
// [R8] Clear-on-read releases interrupt within 500 us
// [R9] Receive loss sets flag and interrupt
// [R10] Transmit failure sets flag and interrupt
// [R11] Other conditions set flag and interrupt
// [R12] Set mask inhibits interrupt within 100 ms
// [R13] Cleared mask resumes interrupt within 100 ms
// [R14] Select asserted: respond within 100 us
// [R15] Select released: stop responding within 100 us
// [R16] Power-down bit set lowers power
// [R17] Power-down cleared restores function within 300 ms
// [R18] Host reads flags after interrupt
// [R19] Flags are read-only to host
// [R20] Flags latch until read; interrupt follows
`timescale 1ns/10ps
`default_nettype none
module mmc_ctrl #(
  parameter int INIT_CYC_P = mmc_pkg::INIT_CYC
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  module_reset_n_in,
  input  wire logic                  low_power_request_in,
  input  wire logic                  bus_select_n_in,
  input  wire mmc_pkg::mmc_cond_s    cond_in,
  input  wire mmc_pkg::mmc_apb_req_s apb_req_in,
  output mmc_pkg::mmc_apb_rsp_s      apb_rsp_out,
  output logic                       irq_out_n,
  output logic                       low_power_out,
  output logic                       bus_respond_out,
  output logic                       ready_out
);
  import mmc_pkg::*;

  localparam logic [31:0] INIT_LAST = 32'(INIT_CYC_P - 1);
  localparam logic [RST_CNT_W-1:0] RST_QUAL = RST_CNT_W'(RST_MIN_CYC);

  function automatic logic at_ofs(input logic [ADDR_W-1:0] a,
                                  input logic [7:0] o);
    at_ofs = (a == o);
  endfunction

  mmc_state_e             st_r;
  logic [31:0]            init_cnt_r;
  logic [RST_CNT_W-1:0]   rst_lo_cnt_r;
  logic                   rst_hit;
  logic                   mod_rst;
  logic                   dnr;
  logic                   init_evt;
  mmc_cond_s              cond_prev_r;
  logic [FLAG_W-1:0]      set_vec;
  logic [FLAG_W-1:0]      flags_r;
  logic [FLAG_W-1:0]      mask_r;
  logic [FLAG_W-1:0]      rd_snap_r;
  logic                   pdown_r;
  logic                   irq_n_r;
  logic                   lp_r;
  logic                   resp_r;
  logic [31:0]            prdata_r;
  logic                   setup;
  logic                   access;
  logic                   mapped;
  logic                   ok;
  logic                   wr_done;
  logic                   rd_flags;
  logic                   wr_mask;
  logic                   wr_ctrl;

  // Reset pin filter: shorter glitches are ignored
  assign rst_hit = !module_reset_n_in && (rst_lo_cnt_r == RST_QUAL); // [R2]

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || module_reset_n_in) begin
      rst_lo_cnt_r <= '0;
    end else if (rst_lo_cnt_r != RST_QUAL) begin
      rst_lo_cnt_r <= rst_lo_cnt_r + 1'b1;
    end
  end

  // Power-on and reset sequencing
  assign init_evt = (st_r == ST_INIT) && (init_cnt_r == INIT_LAST) && !rst_hit;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r       <= ST_INIT; // [R1]
      init_cnt_r <= '0;
    end else if (rst_hit) begin
      st_r       <= ST_HOLD; // [R2]
      init_cnt_r <= '0;
    end else begin
      case (st_r)
        ST_HOLD: begin
          if (module_reset_n_in) begin
            st_r <= ST_INIT; // [R5]
          end
        end
        ST_INIT: begin
          if (init_cnt_r == INIT_LAST) begin
            st_r <= ST_RUN; // [R1] [R5]
          end else begin
            init_cnt_r <= init_cnt_r + 32'h1;
          end
        end
        ST_RUN: begin
          st_r <= ST_RUN;
        end
        default: begin
          st_r <= ST_INIT;
        end
      endcase
    end
  end

  assign mod_rst   = !rst_n_in || (st_r == ST_HOLD);
  assign dnr       = (st_r != ST_RUN); // [R4]
  assign ready_out = !dnr;

  // Flags latch on a condition's rising edge; monitors only count once running
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cond_prev_r <= '0;
    end else begin
      cond_prev_r <= cond_in;
    end
  end

  always_comb begin
    set_vec = '0;
    set_vec[FLG_INIT] = init_evt; // [R4]
    if (st_r == ST_RUN) begin
      set_vec[FLG_LOS +: N_CH] = cond_in.rx_los & ~cond_prev_r.rx_los; // [R9]
      set_vec[FLG_TXF +: N_CH] = cond_in.tx_fault & ~cond_prev_r.tx_fault; // [R10]
      set_vec[FLG_OTH +: N_CH] = cond_in.other & ~cond_prev_r.other; // [R11]
    end
  end

  // Only bits the host actually saw are cleared; a new event wins over clear
  always_ff @(posedge clk_in) begin
    if (mod_rst) begin
      flags_r <= '0;
    end else if (rd_flags) begin
      flags_r <= (flags_r & ~rd_snap_r) | set_vec; // [R8] [R20]
    end else begin
      flags_r <= flags_r | set_vec; // [R20]
    end
  end

  always_ff @(posedge clk_in) begin
    if (mod_rst) begin
      mask_r <= MASK_RST;
    end else if (wr_mask) begin
      mask_r <= apb_req_in.pwdata[FLAG_W-1:0]; // [R12] [R13]
    end
  end

  always_ff @(posedge clk_in) begin
    if (mod_rst) begin
      pdown_r <= PDOWN_RST;
    end else if (wr_ctrl) begin
      pdown_r <= apb_req_in.pwdata[CTL_PDOWN]; // [R16] [R17]
    end
  end

  always_ff @(posedge clk_in) begin
    if (mod_rst) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= ~|(flags_r & ~mask_r); // [R7] [R8] [R12] [R13] [R20]
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      lp_r <= 1'b0;
    end else begin
      lp_r <= low_power_request_in || pdown_r; // [R6] [R16] [R17]
    end
  end

  // Select is honoured only once the module is initialised
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      resp_r <= 1'b0;
    end else begin
      resp_r <= (st_r == ST_RUN) && !bus_select_n_in; // [R3] [R14] [R15]
    end
  end

  assign irq_out_n       = irq_n_r;
  assign low_power_out   = lp_r;
  assign bus_respond_out = resp_r;

  // APB slave: zero wait states, read data prepared in the setup cycle
  assign setup  = apb_req_in.psel && !apb_req_in.penable;
  assign access = apb_req_in.psel && apb_req_in.penable;
  assign mapped = at_ofs(apb_req_in.paddr, OFS_STATUS) || at_ofs(apb_req_in.paddr, OFS_FLAGS)
                  || at_ofs(apb_req_in.paddr, OFS_MASK) || at_ofs(apb_req_in.paddr, OFS_CTRL);
  assign ok      = mapped && resp_r;
  assign wr_done = access && ok && apb_req_in.pwrite;
  // Flag register ignores writes
  assign rd_flags = access && ok && !apb_req_in.pwrite
                    && at_ofs(apb_req_in.paddr, OFS_FLAGS); // [R19]
  assign wr_mask  = wr_done && at_ofs(apb_req_in.paddr, OFS_MASK);
  assign wr_ctrl  = wr_done && at_ofs(apb_req_in.paddr, OFS_CTRL);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prdata_r  <= '0;
      rd_snap_r <= '0;
    end else if (setup) begin
      prdata_r  <= '0;
      rd_snap_r <= '0;
      if (resp_r) begin
        if (at_ofs(apb_req_in.paddr, OFS_STATUS)) begin
          prdata_r[STS_DNR]  <= dnr; // [R4]
          prdata_r[STS_LP]   <= lp_r;
          prdata_r[STS_RESP] <= resp_r;
        end else if (at_ofs(apb_req_in.paddr, OFS_FLAGS)) begin
          prdata_r[FLAG_W-1:0] <= flags_r; // [R18] [R19]
          rd_snap_r            <= flags_r;
        end else if (at_ofs(apb_req_in.paddr, OFS_MASK)) begin
          prdata_r[FLAG_W-1:0] <= mask_r;
        end else if (at_ofs(apb_req_in.paddr, OFS_CTRL)) begin
          prdata_r[CTL_PDOWN] <= pdown_r;
        end
      end
    end
  end

  // One driver for the whole response word; a refused access still completes at once
  assign apb_rsp_out = '{prdata: prdata_r, pready: 1'b1, pslverr: access && !ok};

  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_init_end;
    init_evt;
  endsequence
  sequence s_ready;
    (st_r == ST_RUN) && !dnr && flags_r[FLG_INIT];
  endsequence
  sequence s_cleared;
    flags_r == '0;
  endsequence

  AST_INIT_DONE: assert property (s_init_end |=> s_ready ##1 (irq_out_n == mask_r[FLG_INIT])) // [R4]
    else $error("init end did not clear not-ready or raise interrupt");
  AST_INIT_BOUND: assert property (st_r == ST_INIT |-> init_cnt_r <= INIT_LAST) // [R1]
    else $error("init counter ran past its bound");
  AST_RESET_QUAL: assert property (rst_hit |=> (st_r == ST_HOLD) && dnr) // [R2]
    else $error("qualified reset pulse not taken");
  AST_RESET_SHORT: assert property ((st_r == ST_RUN) && !rst_hit // [R2]
                                    && (rst_lo_cnt_r < RST_QUAL) |=> st_r != ST_HOLD)
    else $error("short reset pulse was taken");
  AST_RESET_RELEASE: assert property ((st_r == ST_HOLD) && module_reset_n_in |=> st_r == ST_INIT) // [R5]
    else $error("reset release did not start init");
  AST_LP_ENTER: assert property (low_power_request_in |=> low_power_out) // [R6]
    else $error("low power not entered");
  AST_IRQ_ON: assert property (!mod_rst && |(flags_r & ~mask_r) |=> !irq_out_n) // [R7]
    else $error("interrupt not asserted for unmasked flag");
  AST_IRQ_OFF: assert property (rd_flags && ((flags_r & ~rd_snap_r) == '0) && (set_vec == '0) // [R8]
                                |=> s_cleared ##1 irq_out_n)
    else $error("interrupt not released after flag read");
  AST_FLAG_SET: assert property (!mod_rst && (set_vec != '0) // [R9] [R10] [R11]
                                 |=> (flags_r & $past(set_vec)) == $past(set_vec))
    else $error("condition did not set its flag");
  AST_FLAG_HOLD: assert property (!mod_rst && !rd_flags // [R20]
                                  |=> (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("flag lost before read");
  AST_MASK_WRITE: assert property (wr_mask && !mod_rst // [R12] [R13]
                                   |=> mask_r == $past(apb_req_in.pwdata[FLAG_W-1:0]))
    else $error("mask write not stored");
  AST_MASK_INHIBIT: assert property (((flags_r & ~mask_r) == '0) |=> irq_out_n) // [R12]
    else $error("masked flag drove interrupt");
  AST_SEL_ON: assert property ((st_r == ST_RUN) && !bus_select_n_in |=> bus_respond_out) // [R14]
    else $error("selected module not responding");
  AST_SEL_OFF: assert property (bus_select_n_in |=> !bus_respond_out ##0 !ok) // [R15]
    else $error("deselected module still responding");
  AST_PD_ENTER: assert property (wr_ctrl && apb_req_in.pwdata[CTL_PDOWN] && !mod_rst // [R16]
                                 |=> pdown_r ##1 low_power_out)
    else $error("power-down write did not lower power");
  AST_PD_EXIT: assert property (!pdown_r && !low_power_request_in |=> !low_power_out) // [R17]
    else $error("power-down cleared but power still low");
  // A host write to the flag word must never clear what it has not read
  AST_FLAG_RO: assert property (access && apb_req_in.pwrite && !mod_rst // [R19]
                                |=> (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("write changed the flag word");
  // Monitors are not trusted until initialisation is over
  AST_COND_GATED: assert property ((st_r != ST_RUN) |-> set_vec[FLAG_W-1:1] == '0) // [R9] [R10] [R11]
    else $error("condition latched before init completed");
endmodule // mmc_ctrl
`default_nettype wire

// file: testbench/mmc_host_model.sv
// Host side model: APB master for the management registers
`timescale 1ns/10ps
`default_nettype none
module mmc_host_model (
  input  wire mmc_pkg::mmc_apb_rsp_s rsp_in,
  input  wire logic                  clk_in,
  output mmc_pkg::mmc_apb_req_s      req_out,
  output logic                       hung_out
);
  import mmc_pkg::*;
  initial begin
    req_out  = '0;
    hung_out = 1'b0;
  end
  // Request held until pready; released data is inverted so a stale word never matches
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    int n;
    @(posedge clk_in);
    req_out <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk_in);
    req_out.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (rsp_in.pready !== 1'b1 && n < 16);
    hung_out <= (n >= 16);
    q = rsp_in.prdata;
    err = rsp_in.pslverr;
    req_out <= '{1'b0, 1'b0, 1'b0, a, ~d};
  endtask
endmodule // mmc_host_model
`default_nettype wire

// file: testbench/test_module_mgmt_control_timing.sv
// Testbench of the module management control block
`timescale 1ns/10ps
`default_nettype none
module test_module_mgmt_control_timing;
  import mmc_pkg::*;
  logic                  clk_in;
  logic                  rst_n_in;
  logic                  mrst_n;
  logic                  lp_req;
  logic                  sel_n;
  mmc_cond_s             cond;
  mmc_apb_req_s          req;
  mmc_apb_rsp_s          rsp;
  logic                  irq_n;
  logic                  lp_out;
  logic                  resp;
  logic                  ready;
  logic                  hung;
  int                    n_mismatch = 0;
  int                    checks_done = 0;

  // Short init count keeps the run brief; init waits exceed 20, reset pulse waits of 30 and 60 straddle the 50-cycle filter
  mmc_ctrl #(.INIT_CYC_P(20)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .module_reset_n_in(mrst_n), .low_power_request_in(lp_req), .bus_select_n_in(sel_n),
    .cond_in(cond), .apb_req_in(req), .apb_rsp_out(rsp), .irq_out_n(irq_n),
    .low_power_out(lp_out), .bus_respond_out(resp), .ready_out(ready));
  mmc_host_model host (.rsp_in(rsp), .clk_in(clk_in), .req_out(req), .hung_out(hung));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_bit(string nm, logic e, logic g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk_in);
  endtask

  // One bus transfer; reads compare data, every transfer compares the error flag
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] e, logic ee);
    logic [31:0] q;
    logic        err;
    host.xfer(w, a, d, q, err);
    if (!w) chk_word("prdata", e, q);
    chk_bit("pslverr", ee, err);
  endtask

  always @(posedge hung) begin
    n_mismatch++;
    stop_test();
  end

  initial begin
    rst_n_in = 1'b0;
    mrst_n = 1'b1;
    lp_req = 1'b0;
    sel_n = 1'b1;
    cond = '0;
    cyc(8);
    rst_n_in <= 1'b1;
    acc(0, OFS_STATUS, 0, 0, 1);
    cyc(25);
    chk_bit("ready", 1, ready);
    chk_bit("irq", 0, irq_n);
    sel_n <= 1'b0;
    cyc(2);
    chk_bit("respond", 1, resp);
    acc(0, OFS_STATUS, 0, 32'h4, 0);
    acc(0, OFS_FLAGS, 0, 32'h1, 0);
    cyc(3);
    chk_bit("irq", 1, irq_n);
    acc(0, OFS_FLAGS, 0, 0, 0);
    acc(0, 8'h04, 0, 0, 1);
    acc(0, OFS_CTRL, 0, 0, 0);
    for (int i = 0; i < FLAG_W - 1; i++) begin
      cond <= 12'(1 << i);
      cyc(3);
      chk_bit("irq", 0, irq_n);
      acc(0, OFS_FLAGS, 0, 32'(1) << (i + 1), 0);
      cond <= '0;
      cyc(3);
      chk_bit("irq", 1, irq_n);
    end
    acc(1, OFS_MASK, 32'h1fff, 0, 0);
    cond <= 12'h001;
    cyc(3);
    chk_bit("irq", 1, irq_n);
    acc(1, OFS_FLAGS, 0, 0, 0);
    acc(0, OFS_MASK, 0, 32'h1fff, 0);
    acc(1, OFS_MASK, 0, 0, 0);
    cond <= '0;
    cyc(3);
    chk_bit("irq", 0, irq_n);
    acc(0, OFS_FLAGS, 0, 32'h2, 0);
    lp_req <= 1'b1;
    cyc(2);
    chk_bit("low power", 1, lp_out);
    acc(0, OFS_STATUS, 0, 32'h6, 0);
    lp_req <= 1'b0;
    acc(1, OFS_CTRL, 32'h1, 0, 0);
    cyc(2);
    chk_bit("low power", 1, lp_out);
    acc(1, OFS_CTRL, 0, 0, 0);
    cyc(2);
    chk_bit("low power", 0, lp_out);
    chk_bit("ready", 1, ready);
    acc(1, OFS_MASK, 32'h1fff, 0, 0);
    mrst_n <= 1'b0;
    cyc(30);
    mrst_n <= 1'b1;
    cyc(2);
    chk_bit("ready", 1, ready);
    mrst_n <= 1'b0;
    cyc(60);
    chk_bit("ready", 0, ready);
    mrst_n <= 1'b1;
    cyc(25);
    chk_bit("ready", 1, ready);
    chk_bit("irq", 0, irq_n);
    acc(0, OFS_MASK, 0, 0, 0);
    sel_n <= 1'b1;
    cyc(2);
    chk_bit("respond", 0, resp);
    acc(0, OFS_STATUS, 0, 0, 1);
    stop_test();
  end
endmodule // test_module_mgmt_control_timing
`default_nettype wire
